/* src/psc_pkg.sv */
// Constants, register map and carrier types for the partition state change controller
package psc_pkg;
  // Sizes of the switch
  localparam int PART_N = 4;
  localparam int PORT_N = 8;
  localparam int PSEL_W = 2;
  localparam int ADDR_W = 12;
  localparam int TMR_W = 18;
  localparam int DLY_W = 16;

  // Partition states held in the control register state field
  localparam logic [1:0] PS_DISABLED = 2'h0;
  localparam logic [1:0] PS_FRESET = 2'h1;
  localparam logic [1:0] PS_ACTIVE = 2'h2;

  // Port modes held in the port control register mode field
  localparam logic [1:0] PM_DISABLED = 2'h0;
  localparam logic [1:0] PM_UNATTACHED = 2'h1;
  localparam logic [1:0] PM_UPSTREAM = 2'h2;
  localparam logic [1:0] PM_DOWNSTREAM = 2'h3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] PART_CTL_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] PART_STS_BASE = 12'h010;
  localparam logic [ADDR_W-1:0] PORT_CTL_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] PORT_STS_BASE = 12'h040;
  localparam logic [ADDR_W-1:0] SE_DLY_ADDR = 12'h060;
  localparam logic [ADDR_W-1:0] PM_DLY_ADDR = 12'h064;
  localparam logic [ADDR_W-1:0] RD_DLY_ADDR = 12'h068;
  localparam logic [ADDR_W-1:0] UB_DLY_ADDR = 12'h06c;

  // Field positions
  localparam int STS_STARTED_BIT = 0;
  localparam int STS_DONE_BIT = 1;
  localparam int STS_BUSY_BIT = 2;
  localparam int STS_STATE_LSB = 4;
  localparam int PCTL_SEL_LSB = 8;
  localparam int PSTS_ATT_BIT = 4;

  // Reset values
  localparam logic [1:0] PART_STATE_RST = PS_DISABLED;
  localparam logic [1:0] PORT_MODE_RST = PM_UNATTACHED;
  localparam logic [DLY_W-1:0] SE_DLY_RST = 16'h0010;
  localparam logic [DLY_W-1:0] PM_DLY_RST = 16'h0040;
  localparam logic [DLY_W-1:0] UB_DLY_RST = 16'h0020;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int RESET_DRAIN_US = 250;
  localparam int RESET_DRAIN_CYC = RESET_DRAIN_US * CLK_MHZ;
  localparam logic [2:0] SETTLE_CYC = 3'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Change sequencer states
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_SETTLE = 2'b01,
    CS_DRAIN = 2'b10
  } psc_cs_type;

  // What one port looks like to the rest of the switch
  typedef struct packed {
    logic attached;
    logic [PSEL_W-1:0] part;
    logic [1:0] mode;
  } psc_port_type;
endpackage

/* src/psc_delay.sv */
// Loadable down-counter that times one partition's change latency
`timescale 1ns/10ps
module psc_delay
  import psc_pkg::*;
#(
  parameter int W = TMR_W
) (
  input wire logic mclk_in, // Core clock
  input wire logic rst_in, // Async reset, active high
  input wire logic load_in, // Start a new count
  input wire logic [W-1:0] value_in, // Cycles to count
  output logic zero_out // Count has expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } psc_dly_state_type;

  psc_dly_state_type s_reg, s_next;

  // Count down to zero and rest there
  always_comb begin
    s_next = s_reg;
    if (load_in) begin
      s_next.cnt = value_in;
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign zero_out = (s_reg.cnt == '0);
endmodule

/* src/psc_port_map.sv */
// Resolves one port's effective mode and attachment from its control fields
`timescale 1ns/10ps
module psc_port_map
  import psc_pkg::*;
(
  input wire logic [1:0] mode_in, // Mode field of the port
  input wire logic [PSEL_W-1:0] sel_in, // Partition select field
  input wire logic [PART_N-1:0][1:0] part_state_in, // States of all partitions
  output psc_port_type port_out // Effective mode and attachment
);
  logic operational;

  // Each port looks only at its own fields and its selected partition's state, never at another port
  always_comb begin
    operational = (mode_in == PM_UPSTREAM) || (mode_in == PM_DOWNSTREAM);
    port_out.attached = operational;
    port_out.part = operational ? sel_in : '0;
    port_out.mode = mode_in;
    if (operational && part_state_in[sel_in] == PS_DISABLED) begin
      port_out = '0;
    end
  end
endmodule

/* src/psc_top.sv */
// Partition state change controller with AXI4-Lite register access
`timescale 1ns/10ps

module psc_top
  import psc_pkg::*;
#(
  parameter int RD_DLY_RST = RESET_DRAIN_CYC // Reset drain default, shorten for sim
) (
  input wire logic mclk_in, // Core clock, 200 MHz
  input wire logic rst_in, // Async reset, active high
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [PART_N-1:0] partition_reset_input_n_in, // Partition reset pins, low
  input wire logic [PART_N-1:0] port_mode_busy_in, // Port mode change running
  output psc_port_type [PORT_N-1:0] port_info_out, // Effective port modes
  output logic [PART_N-1:0] partition_freset_out, // Partition held in reset
  output logic [PART_N-1:0] partition_init_out // Pulse: reload partition regs
);
  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [PART_N-1:0][1:0] part_state;
    logic [PART_N-1:0][1:0] old_state;
    logic [PART_N-1:0] started;
    logic [PART_N-1:0] done;
    logic [PART_N-1:0] side_fx;
    logic [PART_N-1:0][1:0] cs;
    logic [PART_N-1:0][2:0] settle;
    logic [PART_N-1:0] init;
    logic [PART_N-1:0] freset;
    logic [PORT_N-1:0][1:0] port_mode;
    logic [PORT_N-1:0][PSEL_W-1:0] port_sel;
    psc_port_type [PORT_N-1:0] port_eff;
    logic [DLY_W-1:0] se_dly;
    logic [DLY_W-1:0] pm_dly;
    logic [DLY_W-1:0] rd_dly;
    logic [DLY_W-1:0] ub_dly;
  } psc_state_type;

  psc_state_type s_reg, s_next;
  psc_port_type [PORT_N-1:0] port_comb;
  logic [PART_N-1:0] tmr_load;
  logic [PART_N-1:0][TMR_W-1:0] tmr_value;
  logic [PART_N-1:0] tmr_zero;
  logic do_write;
  logic [31:0] wmerge;

  //////////////////////////////////////////////////////////////////////////////
  // Per-port mode resolution and per-partition latency timers

  for (genvar q = 0; q < PORT_N; q++) begin : g_port
    psc_port_map u_map (
      .mode_in(s_reg.port_mode[q]),
      .sel_in(s_reg.port_sel[q]),
      .part_state_in(s_reg.part_state),
      .port_out(port_comb[q])
    );
  end

  for (genvar p = 0; p < PART_N; p++) begin : g_part
    psc_delay #(.W(TMR_W)) u_dly (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .load_in(tmr_load[p]),
      .value_in(tmr_value[p]),
      .zero_out(tmr_zero[p])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Apply byte strobes over the current register contents
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = cur;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Current contents of a register, with hit flag for the unmapped answer
  function automatic logic [32:0] read_reg(input psc_state_type st, input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    r = '0;
    for (int p = 0; p < PART_N; p++) begin
      if (a == PART_CTL_BASE + ADDR_W'(4 * p)) begin
        r = {1'b1, 30'h0, st.part_state[p]};
      end
      if (a == PART_STS_BASE + ADDR_W'(4 * p)) begin
        r[32] = 1'b1;
        r[STS_STARTED_BIT] = st.started[p];
        r[STS_DONE_BIT] = st.done[p];
        r[STS_BUSY_BIT] = (st.cs[p] != CS_IDLE);
        r[STS_STATE_LSB +: 2] = st.part_state[p];
      end
    end
    for (int q = 0; q < PORT_N; q++) begin
      if (a == PORT_CTL_BASE + ADDR_W'(4 * q)) begin
        r[32] = 1'b1;
        r[1:0] = st.port_mode[q];
        r[PCTL_SEL_LSB +: PSEL_W] = st.port_sel[q];
      end
      if (a == PORT_STS_BASE + ADDR_W'(4 * q)) begin
        r[32] = 1'b1;
        r[1:0] = st.port_eff[q].mode;
        r[PSTS_ATT_BIT] = st.port_eff[q].attached;
        r[PCTL_SEL_LSB +: PSEL_W] = st.port_eff[q].part;
      end
    end
    if (a == SE_DLY_ADDR) r = {1'b1, 16'h0, st.se_dly};
    if (a == PM_DLY_ADDR) r = {1'b1, 16'h0, st.pm_dly};
    if (a == RD_DLY_ADDR) r = {1'b1, 16'h0, st.rd_dly};
    if (a == UB_DLY_ADDR) r = {1'b1, 16'h0, st.ub_dly};
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic [32:0] rd;
    logic [32:0] cur;
    logic [TMR_W-1:0] dly;
    logic pin_ok;
    s_next = s_reg;
    rd = '0;
    cur = '0;
    dly = '0;
    pin_ok = 1'b0;
    tmr_load = '0;
    tmr_value = '0;
    s_next.init = '0;
    s_next.port_eff = port_comb;

    // Write address and data are taken in either order and held until paired
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    do_write = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    cur = read_reg(s_reg, s_reg.awaddr);
    wmerge = merge(cur[31:0], s_reg.wdata, s_reg.wstrb);
    if (s_axi_bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Change sequencer per partition; the done flag is set before any clear
    for (int p = 0; p < PART_N; p++) begin
      case (s_reg.cs[p])
        CS_IDLE: begin
        end
        CS_SETTLE: begin
          // A couple of cycles let effective port modes settle before timing
          if (s_reg.settle[p] != '0) begin
            s_next.settle[p] = s_reg.settle[p] - 1'b1;
          end else begin
            dly = '0;
            if (s_reg.part_state[p] == PS_FRESET) begin
              dly = TMR_W'(s_reg.rd_dly);
            end
            if (s_reg.side_fx[p]) begin
              dly = dly + TMR_W'(s_reg.se_dly) + TMR_W'(s_reg.pm_dly);
            end
            tmr_load[p] = 1'b1;
            tmr_value[p] = dly;
            s_next.cs[p] = CS_DRAIN;
          end
        end
        CS_DRAIN: begin
          // Completion into active waits while the reset pin is asserted
          pin_ok = partition_reset_input_n_in[p] ||
                   s_reg.part_state[p] != PS_ACTIVE ||
                   s_reg.old_state[p] == PS_ACTIVE;
          if (tmr_zero[p] && !tmr_load[p] && !port_mode_busy_in[p] && pin_ok) begin
            s_next.done[p] = 1'b1;
            s_next.cs[p] = CS_IDLE;
          end
        end
        default: begin
          s_next.cs[p] = CS_IDLE;
        end
      endcase
      // Partition held in reset by its state or its pin
      s_next.freset[p] = (s_next.part_state[p] == PS_FRESET) ||
                         !partition_reset_input_n_in[p];
    end

    // Register writes; illegal state code 3 is not a state and is ignored
    if (do_write) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = cur[32] ? RESP_OKAY : RESP_SLVERR;
      for (int p = 0; p < PART_N; p++) begin
        if (s_reg.awaddr == PART_CTL_BASE + ADDR_W'(4 * p) && s_reg.wstrb[0] &&
            wmerge[1:0] != 2'h3) begin
          s_next.old_state[p] = s_reg.part_state[p];
          s_next.part_state[p] = wmerge[1:0];
          s_next.started[p] = 1'b1;
          s_next.done[p] = 1'b0;
          s_next.cs[p] = CS_SETTLE;
          s_next.settle[p] = SETTLE_CYC;
          s_next.init[p] = (wmerge[1:0] == PS_FRESET) &&
                           (s_reg.part_state[p] != PS_FRESET);
          // Entering or leaving disabled changes modes of attached ports
          s_next.side_fx[p] = 1'b0;
          for (int q = 0; q < PORT_N; q++) begin
            if (s_reg.port_mode[q][1] && s_reg.port_sel[q] == PSEL_W'(p) &&
                ((s_reg.part_state[p] == PS_DISABLED) != (wmerge[1:0] == PS_DISABLED))) begin
              s_next.side_fx[p] = 1'b1;
            end
          end
        end
      end
      for (int q = 0; q < PORT_N; q++) begin
        if (s_reg.awaddr == PORT_CTL_BASE + ADDR_W'(4 * q)) begin
          s_next.port_mode[q] = wmerge[1:0];
          s_next.port_sel[q] = wmerge[PCTL_SEL_LSB +: PSEL_W];
        end
      end
      if (s_reg.awaddr == SE_DLY_ADDR) s_next.se_dly = wmerge[DLY_W-1:0];
      if (s_reg.awaddr == PM_DLY_ADDR) s_next.pm_dly = wmerge[DLY_W-1:0];
      if (s_reg.awaddr == RD_DLY_ADDR) s_next.rd_dly = wmerge[DLY_W-1:0];
      if (s_reg.awaddr == UB_DLY_ADDR) s_next.ub_dly = wmerge[DLY_W-1:0];
    end

    // Reads answer one cycle after the address is taken
    if (s_axi_rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd = read_reg(s_reg, s_axi_araddr);
      s_next.rvalid = 1'b1;
      s_next.rdata = rd[31:0];
      s_next.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.part_state <= {PART_N{PART_STATE_RST}};
      s_reg.old_state <= {PART_N{PART_STATE_RST}};
      s_reg.port_mode <= {PORT_N{PORT_MODE_RST}};
      s_reg.se_dly <= SE_DLY_RST;
      s_reg.pm_dly <= PM_DLY_RST;
      s_reg.rd_dly <= DLY_W'(RD_DLY_RST);
      s_reg.ub_dly <= UB_DLY_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs; a single outstanding write or read keeps the slave simple

  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign port_info_out = s_reg.port_eff;
  assign partition_freset_out = s_reg.freset;
  assign partition_init_out = s_reg.init;
endmodule

/* verif/psc_checker.sv */
// Port-level assertions for the partition state change controller
`timescale 1ns/10ps
module psc_checker
  import psc_pkg::*;
(
  input wire logic mclk_in, // Core clock
  input wire logic rst_in, // Async reset, active high
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [PART_N-1:0] partition_reset_input_n_in, // Reset pins, low
  input wire psc_port_type [PORT_N-1:0] port_info_out, // Effective port modes
  input wire logic [PART_N-1:0] partition_freset_out, // Partition in reset
  input wire logic [PART_N-1:0] partition_init_out // Register reload pulse
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  // An attached port must be operational and an operational one attached
  logic bad_attach;
  always_comb begin
    bad_attach = 1'b0;
    for (int i = 0; i < PORT_N; i++) begin
      if (port_info_out[i].attached != port_info_out[i].mode[1]) bad_attach = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write response late");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read data late");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken while busy");
  property p_init_pulse;
    partition_init_out != 4'h0 |=> partition_init_out == 4'h0;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("reload pulse too long");
  property p_init_reset;
    partition_init_out != 4'h0 |-> ##[0:2] (partition_freset_out != 4'h0);
  endproperty
  a_init_reset: assert property (p_init_reset) else $error("reload without reset");
  property p_pin_reset;
    1'b1 |=> (partition_freset_out | $past(partition_reset_input_n_in)) == 4'hf;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not shown");
  property p_attach;
    !bad_attach;
  endproperty
  a_attach: assert property (p_attach) else $error("attachment wrong");
endmodule

bind psc_top psc_checker u_chk (.mclk_in, .rst_in, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .partition_reset_input_n_in,
  .port_info_out, .partition_freset_out, .partition_init_out);

/* verif/psc_cfg_master.sv */
// Configuration master model: AXI4-Lite register access and change polling
`timescale 1ns/10ps
module psc_cfg_master
  import psc_pkg::*;
(
  input wire logic mclk_in, // Core clock
  output logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  output logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  output logic [31:0] s_axi_wdata, // Write data
  output logic [3:0] s_axi_wstrb, // Byte strobes
  output logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Response valid
  output logic s_axi_bready, // Response ready
  output logic [ADDR_W-1:0] s_axi_araddr, // Read address
  output logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read valid
  output logic s_axi_rready // Read ready
);
  // Idle bus from time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response ready comes late on purpose so the slave must hold its answer
  task automatic write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [1:0] r);
    bit aw;
    bit w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge mclk_in);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk_in); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge mclk_in);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk_in); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge mclk_in);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Loader-style timer setup before a change and restore afterwards
  task automatic set_timers(input logic [15:0] se, pm, rd, ub);
    logic [1:0] r;
    write(SE_DLY_ADDR, {16'h0, se}, r);
    write(PM_DLY_ADDR, {16'h0, pm}, r);
    write(RD_DLY_ADDR, {16'h0, rd}, r);
    write(UB_DLY_ADDR, {16'h0, ub}, r);
  endtask

  // Nothing else is started on a partition until its change is done
  task automatic wait_done(input int p, output int cyc);
    logic [31:0] d;
    logic [1:0] r;
    time t0;
    t0 = $time;
    d = 32'h0;
    while (d[STS_DONE_BIT] !== 1'b1) read(PART_STS_BASE + 12'(4 * p), d, r);
    cyc = int'(($time - t0) / 5);
  endtask
endmodule

/* verif/tb_psc_top.sv */
// Self-checking testbench for the partition state change controller
`timescale 1ns/10ps
module tb_psc_top;
  import psc_pkg::*;
  localparam int RDC = 40; // Shortened reset drain count
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [PART_N-1:0] partition_reset_input_n_in = 4'hf;
  logic [PART_N-1:0] port_mode_busy_in = 4'h0;
  logic [PART_N-1:0] partition_freset_out, partition_init_out;
  psc_port_type [PORT_N-1:0] port_info_out;
  logic [1:0] pst [PART_N];
  logic [9:0] pctl [PORT_N];
  logic [31:0] lfsr = 32'h00017e09;
  int miscompares = 0;
  int checked = 0;

  psc_top #(.RD_DLY_RST(RDC)) DUT (.mclk_in, .rst_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .partition_reset_input_n_in,
    .port_mode_busy_in, .port_info_out, .partition_freset_out, .partition_init_out);
  psc_cfg_master u_mst (.mclk_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the limit of 60000 cycles is over a hundred times the expected run
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial begin
    #300000;
    miscompares++;
    print_verdict;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Operational ports of a disabled partition show as disabled and unattached
  function automatic psc_port_type exp_port(input logic [1:0] m, input logic [1:0] s,
                                            input logic [1:0] st);
    if (!m[1]) return '{1'b0, 2'h0, m};
    if (st == PS_DISABLED) return '{1'b0, 2'h0, PM_DISABLED};
    return '{1'b1, s, m};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_mst.read(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_mst.write(a, d, r);
    chk(r, er);
  endtask

  task automatic print_verdict;
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int c;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    // Reset values, then an unmapped read and write
    for (int i = 0; i < PART_N; i++) begin
      rd(PART_CTL_BASE + 12'(4 * i), 32'h0, RESP_OKAY);
      pst[i] = PS_DISABLED;
    end
    for (int i = 0; i < PORT_N; i++) begin
      rd(PORT_CTL_BASE + 12'(4 * i), 32'h1, RESP_OKAY);
      chk(port_info_out[i], 32'h1);
      pctl[i] = 10'h001;
    end
    rd(RD_DLY_ADDR, 32'(RDC), RESP_OKAY);
    rd(12'h100, 32'h0, RESP_SLVERR);
    wr(12'h104, 32'h1, RESP_SLVERR);
    $display("Test reset values done");
    // Plain change with zero timers
    u_mst.set_timers(16'h0, 16'h0, 16'h0, 16'h0);
    wr(PART_CTL_BASE + 12'h4, 32'h2, RESP_OKAY);
    rd(PART_STS_BASE + 12'h4, 32'h25, RESP_OKAY);
    u_mst.wait_done(1, c);
    chk(c <= 20, 1'b1);
    rd(PART_STS_BASE + 12'h4, 32'h23, RESP_OKAY);
    $display("Test plain change done");
    // Entry to fundamental reset waits out the drain count
    u_mst.set_timers(16'h0, 16'h0, 16'(RDC), 16'h0);
    wr(PART_CTL_BASE + 12'h4, 32'h1, RESP_OKAY);
    pst[1] = PS_FRESET;
    rd(PART_STS_BASE + 12'h4, 32'h15, RESP_OKAY);
    chk(partition_freset_out[1], 1'b1);
    u_mst.wait_done(1, c);
    chk(c >= RDC - 5 && c <= RDC + 20, 1'b1);
    $display("Test reset drain done");
    // A low reset pin holds completion of a change to active
    u_mst.set_timers(16'h0, 16'h0, 16'h0, 16'h0);
    partition_reset_input_n_in[2] <= 1'b0;
    wr(PART_CTL_BASE + 12'h8, 32'h2, RESP_OKAY);
    pst[2] = PS_ACTIVE;
    repeat (30) @(posedge mclk_in);
    rd(PART_STS_BASE + 12'h8, 32'h25, RESP_OKAY);
    partition_reset_input_n_in[2] <= 1'b1;
    u_mst.wait_done(2, c);
    chk(c <= 20, 1'b1);
    $display("Test reset pin hold done");
    // Port attached to a disabled partition, then the partition activated
    wr(PORT_CTL_BASE + 12'hc, 32'h2, RESP_OKAY);
    pctl[3] = 10'h002;
    repeat (2) @(posedge mclk_in);
    chk(port_info_out[3], 32'h0);
    wr(PART_CTL_BASE, 32'h2, RESP_OKAY);
    pst[0] = PS_ACTIVE;
    port_mode_busy_in[0] <= 1'b1; // Mode change caused by the state change itself
    repeat (30) @(posedge mclk_in);
    rd(PART_STS_BASE, 32'h25, RESP_OKAY);
    port_mode_busy_in[0] <= 1'b0;
    u_mst.wait_done(0, c);
    chk(port_info_out[3], 32'h12);
    $display("Test port mode side effect done");
    // Random port control writes; every port checked each time
    for (int n = 0; n < 24; n++) begin
      lfsr = next_rand(lfsr);
      pctl[lfsr[2:0]] = {lfsr[9:8], 6'h0, lfsr[5:4]};
      wr(PORT_CTL_BASE + 12'(4 * lfsr[2:0]), {22'h0, pctl[lfsr[2:0]]}, RESP_OKAY);
      repeat (2) @(posedge mclk_in);
      for (int i = 0; i < PORT_N; i++) begin
        chk(port_info_out[i], exp_port(pctl[i][1:0], pctl[i][9:8], pst[pctl[i][9:8]]));
      end
    end
    $display("Test random port map done");
    u_mst.set_timers(SE_DLY_RST, PM_DLY_RST, 16'(RDC), UB_DLY_RST);
    rd(SE_DLY_ADDR, 32'h10, RESP_OKAY);
    print_verdict;
  end
endmodule
